// *** rtl/code_protect_regs.svh ***
// constants for the program memory code-protection gate
`ifndef CODE_PROTECT_REGS_SVH
`define CODE_PROTECT_REGS_SVH
`define PMODE_WIDTH        3
`define PMODE_PROTECTED    3'h0
`define PMODE_MICROPROC    3'h2
`define PMODE_EXTENDED     3'h3
`define PMODE_RESET        3'h7
`define ADDR_WIDTH         16
`define DATA_WIDTH         16
`define INTERNAL_TOP_RESET 16'h0fff
`endif

// *** rtl/code_protect_pkg.sv ***
// types shared by the code-protection gate
`default_nettype none
package code_protect_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_GRANT = 3'b010,
        ST_BLOCK = 3'b100
    } gate_state_e;
endpackage
`default_nettype wire

// *** rtl/code_protect_if.sv ***
// access request carrier between the gate and its checker
`timescale 1ns/100ps
`default_nettype none
`include "code_protect_regs.svh"
interface code_protect_if;
    logic [`ADDR_WIDTH-1:0] issue_pc;
    logic [`ADDR_WIDTH-1:0] internal_top;
    logic [`PMODE_WIDTH-1:0] pmode;
    logic                   verify_mode;
    logic                   allow;
    modport gate  (output issue_pc, output internal_top, output pmode, output verify_mode, input allow);
    modport check (input issue_pc, input internal_top, input pmode, input verify_mode, output allow);
endinterface
`default_nettype wire

// *** rtl/code_protect_check.sv ***
// combinational permission decision for one program memory access
`timescale 1ns/100ps
`default_nettype none
`include "code_protect_regs.svh"
module code_protect_check
    import code_protect_pkg::*;
(
    code_protect_if.check bus
);
    wire protected_mode;
    wire pc_internal;
    // protection only when the mode field is all zeros
    assign protected_mode = (bus.pmode == `PMODE_PROTECTED);              // R1
    // bound compare of the issuing instruction address
    assign pc_internal    = (bus.issue_pc <= bus.internal_top);           // R6
    // protected: only internal code passes, verify read-out is refused too;
    // unprotected: everything passes, verify read-out included
    assign bus.allow = !protected_mode || (pc_internal && !bus.verify_mode); // R2 R3 R4
endmodule // code_protect_check
`default_nettype wire

// *** rtl/code_protect_gate.sv ***
// program memory code-protection gate between core and program memory
//
// Notes on behaviour
// R1 - mode field all zeros selects protection
// R2 - internal code still reads and writes memory
// R3 - external code access to memory blocked
// R4 - unprotected part allows verify read-out
// R5 - bus modes hand ports c,d,e to bus
// R6 - compare issuing address against internal top
`timescale 1ns/100ps
`default_nettype none
`include "code_protect_regs.svh"
module code_protect_gate
    import code_protect_pkg::*;
(
    input  wire  logic                    clk,
    input  wire  logic                    rst_n,
    input  wire  logic [`PMODE_WIDTH-1:0] processor_mode_select,
    input  wire  logic [`ADDR_WIDTH-1:0]  internal_top,
    input  wire  logic                    verify_req,
    input  wire  logic                    acc_req,
    input  wire  logic                    acc_write,
    input  wire  logic [`ADDR_WIDTH-1:0]  acc_pc,
    input  wire  logic [`ADDR_WIDTH-1:0]  acc_addr,
    input  wire  logic [`DATA_WIDTH-1:0]  acc_wdata,
    input  wire  logic [`DATA_WIDTH-1:0]  mem_rdata,
    output var   logic                    mem_rd,
    output var   logic                    mem_wr,
    output var   logic [`ADDR_WIDTH-1:0]  mem_addr,
    output var   logic [`DATA_WIDTH-1:0]  mem_wdata,
    output var   logic                    acc_done,
    output var   logic                    acc_blocked,
    output var   logic [`DATA_WIDTH-1:0]  acc_rdata,
    output var   logic                    sysbus_enable,
    output var   logic                    code_protected
);
    ////////////////////////////////////////////////////////////////////////////
    code_protect_if      link();
    gate_state_e         state;
    gate_state_e         next_state;
    logic                pending_write;

    ////////////////////////////////////////////////////////////////////////////
    // mode field decoders for the status flags; the grant path must agree on
    // the encodings and decodes the protected one again in code_protect_check
    function automatic logic mode_is_protected
    (
        input logic [`PMODE_WIDTH-1:0] mode
    );
        return (mode == `PMODE_PROTECTED);                                // R1
    endfunction

    function automatic logic mode_is_bus
    (
        input logic [`PMODE_WIDTH-1:0] mode
    );
        return (mode == `PMODE_MICROPROC) || (mode == `PMODE_EXTENDED);   // R5
    endfunction

    // state decoder; the answer cycle covers both outcomes of a request
    function automatic logic state_is_answer
    (
        input gate_state_e s
    );
        return (s == ST_GRANT) || (s == ST_BLOCK);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // carrier towards the permission check; the check is combinational, so
    // the request fields only have to be valid while acc_req is high
    assign link.issue_pc     = acc_pc;
    assign link.internal_top = internal_top;
    assign link.pmode        = processor_mode_select;
    assign link.verify_mode  = verify_req;

    // range compare and verify refusal sit in one small module, so a second
    // requester could share them without copying the decode
    code_protect_check u_check
    (
        .bus (link.check)
    );

    ////////////////////////////////////////////////////////////////////////////
    // decoded mode bits; ports c,d,e become bus only in bus modes
    wire                 bus_mode;
    wire                 prot_now;
    wire                 grant;
    wire                 idle;
    wire                 take;
    wire                 next_mem_rd;
    wire                 next_mem_wr;
    wire                 next_acc_done;
    wire                 next_acc_blocked;
    wire                 load_rdata;
    wire                 clear_rdata;

    assign bus_mode = mode_is_bus(processor_mode_select);                 // R5
    assign prot_now = mode_is_protected(processor_mode_select);           // R1
    // one allow bit carries both the range compare and the verify refusal
    assign grant    = link.allow;                                         // R2 R3 R4

    // a request is looked at only while idle; one in a busy cycle is dropped
    // without an answer, so the core must keep its requests spaced out
    assign idle     = (state == ST_IDLE);
    assign take     = idle && acc_req;

    // strobes only for granted requests: a blocked access never shows at memory
    assign next_mem_rd = take && grant && !acc_write;                     // R2 R3
    assign next_mem_wr = take && grant && acc_write;                      // R2 R3

    // answer side: done for both outcomes, blocked only for a refusal
    assign next_acc_done    = state_is_answer(state);
    assign next_acc_blocked = (state == ST_BLOCK);                        // R3
    // read data is taken while the read strobe is out; memory must answer
    // within that cycle, there is no wait state
    assign load_rdata       = (state == ST_GRANT) && !pending_write;
    assign clear_rdata      = (state == ST_BLOCK);                        // R3

    // next state: one access in flight; the answer cycle always returns to idle
    // an unknown state code falls back to idle rather than hanging the core
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (acc_req)
                    next_state = grant ? ST_GRANT : ST_BLOCK;             // R2 R3
            end
            ST_GRANT: next_state = ST_IDLE;
            ST_BLOCK: next_state = ST_IDLE;
            default:  next_state = ST_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // memory strobes, one cycle each; never both at once
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
        end
        else
        begin
            mem_rd <= next_mem_rd;                                        // R2 R3
            mem_wr <= next_mem_wr;                                        // R2 R3
        end
    end

    // address and data are captured on every take, refused ones too; memory
    // ignores them without a strobe, and the hold saves a mux on the pins
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_addr      <= '0;
            mem_wdata     <= '0;
            pending_write <= 1'b0;
        end
        else if (take)
        begin
            mem_addr      <= acc_addr;
            mem_wdata     <= acc_wdata;
            pending_write <= acc_write;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // answer to the core one cycle after the strobe
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_done    <= 1'b0;
            acc_blocked <= 1'b0;
        end
        else
        begin
            acc_done    <= next_acc_done;
            acc_blocked <= next_acc_blocked;                              // R3
        end
    end

    // read data holds between accesses; a refused access returns zero so no
    // stale word from an earlier granted read reaches external code
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            acc_rdata <= '0;
        else if (load_rdata)
            acc_rdata <= mem_rdata;                                       // R2
        else if (clear_rdata)
            acc_rdata <= '0;                                              // R3
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode status flags, registered so the outputs come from flops; the mode
    // field is configuration, so one cycle of lag costs nothing
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sysbus_enable  <= 1'b0;
            code_protected <= 1'b0;
        end
        else
        begin
            sysbus_enable  <= bus_mode;                                   // R5
            code_protected <= prot_now;                                   // R1
        end
    end
endmodule // code_protect_gate
`default_nettype wire

// *** tb/code_protect_props.sv ***
// port assertions for the code-protection gate
`timescale 1ns/100ps
`default_nettype none
module code_protect_props (
    input wire logic        clk, rst_n, verify_req, acc_req, mem_rd, mem_wr,
    input wire logic        acc_done, acc_blocked, sysbus_enable, code_protected,
    input wire logic [2:0]  processor_mode_select,
    input wire logic [15:0] internal_top, acc_pc, acc_rdata
);
    // refused: protected mode with code outside the internal range or a verify read
    wire blk = processor_mode_select == 3'h0 && (acc_pc > internal_top || verify_req);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_mode_flag: assert property ($past(rst_n) |-> code_protected == ($past(processor_mode_select) == 3'h0))
        else $error("protect flag wrong");
    a_bus_mode: assert property ($past(rst_n) |-> sysbus_enable == ($past(processor_mode_select[2:1]) == 2'b01))
        else $error("bus enable wrong");
    a_grant_path: assert property (acc_req && !blk |=> (mem_rd || mem_wr) ##1 acc_done && !acc_blocked)
        else $error("grant path wrong");
    a_block_path: assert property (acc_req && blk |=> !mem_rd && !mem_wr ##1 acc_done && acc_blocked)
        else $error("block path wrong");
    a_strobe_cause: assert property (mem_rd || mem_wr |-> $past(acc_req) && !$past(blk))
        else $error("strobe without grant");
    a_block_pulse: assert property (acc_blocked |-> acc_done ##1 !acc_blocked)
        else $error("blocked pulse wrong");
    a_block_zero: assert property (acc_blocked |-> acc_rdata == 16'h0000)
        else $error("blocked read data not zero");
endmodule // code_protect_props
`default_nettype wire

// *** tb/prog_mem_model.sv ***
// program memory stand-in, read data within the strobe cycle
`timescale 1ns/100ps
`default_nettype none
module prog_mem_model (
    input  wire logic        mem_rd,
    input  wire logic [15:0] mem_addr,
    output var  logic [15:0] mem_rdata
);
    // the gate takes read data while the strobe is out, so the answer is
    // combinational; outside a read the word is inverted and never looks valid
    assign mem_rdata = mem_rd ? mem_addr ^ 16'h5a5a : ~(mem_addr ^ 16'h5a5a);
endmodule // prog_mem_model
`default_nettype wire

// *** tb/tb_program_memory_code_protect.sv ***
// self-checking bench for the code-protection gate
`timescale 1ns/100ps
`default_nettype none
module tb_program_memory_code_protect;
    logic        clk = 0, rst_n = 0, verify_req = 0, acc_req = 0, acc_write = 0;
    logic [2:0]  processor_mode_select = 3'h7;
    logic [15:0] internal_top = 16'h0fff, acc_pc = 0, acc_addr = 0, acc_wdata = 0, mem_rdata, last_rd = 0;
    logic        mem_rd, mem_wr, acc_done, acc_blocked, sysbus_enable, code_protected;
    logic [15:0] mem_addr, mem_wdata, acc_rdata;
    int          n_mismatch = 0, cmp_count = 0;
    code_protect_gate dut (.*);
    prog_mem_model mem (.mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata));
    initial forever #4 clk = ~clk;
    task automatic chk(input logic [15:0] seen, exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // true when the access must reach memory
    function automatic logic granted(logic [2:0] m, logic v, logic [15:0] pc);
        return !(m == 3'h0 && (pc > internal_top || v));
    endfunction
    // requests at the minimum spacing of two cycles; odd passes run protected
    initial
    begin
        logic g;
        void'($urandom(32'h6ca9e3c0));
        repeat (5) @(negedge clk);
        rst_n = 1;
        for (int i = 0; i < 48; i++)
        begin
            // mid-run reset between two accesses; every output must fall to zero
            if (i == 24)
            begin
                rst_n = 0;
                @(negedge clk);
                chk({mem_rd, mem_wr, acc_done, acc_blocked, sysbus_enable, code_protected}, 16'h0000);
                chk(acc_rdata | mem_addr | mem_wdata, 16'h0000);
                last_rd = 16'h0000;
                internal_top = 16'h1fff;
                rst_n = 1;
            end
            processor_mode_select = i[0] ? 3'h0 : i[3:1];
            acc_pc = i == 1 ? internal_top : i == 3 ? internal_top + 16'h1
                   : 16'($urandom) & (i[2] ? internal_top : 16'hffff);
            verify_req = i > 5 && $urandom_range(1, 0);
            acc_write = $urandom_range(1, 0);
            acc_addr = 16'($urandom);
            acc_wdata = 16'($urandom);
            g = granted(processor_mode_select, verify_req, acc_pc);
            acc_req = 1;
            @(negedge clk) acc_req = 0;
            chk({mem_rd, mem_wr}, {g && !acc_write, g && acc_write});
            chk(mem_addr, acc_addr);
            if (g) chk(acc_write ? mem_wdata : mem_addr, acc_write ? acc_wdata : acc_addr);
            last_rd = !g ? 16'h0000 : acc_write ? last_rd : acc_addr ^ 16'h5a5a;
            @(negedge clk);
            chk({acc_done, acc_blocked, sysbus_enable}, {1'b1, !g, processor_mode_select[2:1] == 2'b01});
            chk(code_protected, processor_mode_select == 3'h0);
            chk(acc_rdata, last_rd);
        end
        wrap_up();
    end
endmodule // tb_program_memory_code_protect
bind code_protect_gate code_protect_props props (.*);
`default_nettype wire
